// ===== dram_cke_reset_odt_timing.v
// Memory-side CKE reset handling and on-die termination timing regime selection
// Operation
// - Reset discards contents; device works again after reinitialization.
// - In reset, all inputs except CKE are ignored.
// - Raising CKE may finish an interrupted read burst.
// - ODT honoured only after EMR enables termination and mode delay elapses.
// - ODT ignored in self refresh and just after enabling termination.
// - CKE high or fast-exit active power-down uses synchronous delays.
// - Slow-exit or precharge power-down uses asynchronous delays.
// - ODT off before entry: lead time met synchronous, else asynchronous.
// - ODT on before entry: lead time met synchronous, else asynchronous.
// - ODT off after any exit: lag met synchronous, else asynchronous.
// - ODT on after slow or precharge exit: lag met synchronous, else asynchronous.
// - Termination value changes by EMR set one cycle after the mode update delay.
// - Termination value field is EMR address bits A6 and A2.
// - MR bit 12 set selects slow exit, clear selects fast exit.
`timescale 1ns/1ps
`default_nettype none
`include "dram_odt_consts.vh"
module dram_cke_reset_odt_timing (
  // Clock and reset
  input  wire          clk_in,
  input  wire          rst_n_in,
  // Memory inputs
  input  wire          cke_in,
  input  wire          odt_in,
  input  wire [3:0]    cmd_in,
  input  wire [2:0]    ba_in,
  input  wire [13:0]   addr_in,
  // Status
  output reg           in_reset_out,
  output reg           need_init_out,
  output reg           powered_down_out,
  output reg           self_refresh_out,
  output reg           async_mode_out,
  output reg           slow_exit_out,
  output reg  [1:0]    rtt_sel_out,
  output reg           rtt_pending_out,
  output wire          term_on_out,
  output reg           resume_read_out
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam ST_RESET = 2'h0;
  localparam ST_ACT   = 2'h1;
  localparam ST_PD    = 2'h2;
  localparam ST_SR    = 2'h3;

  reg  [1:0]        st_q, st_d;
  reg               cke_q;
  reg               odt_q;
  reg               bank_open_q;
  reg               pd_slow_q;
  reg               odt_en_q;
  reg  [`CNT_W-1:0] mod_cnt_q;
  reg  [`CNT_W-1:0] entry_cnt_q;
  reg  [`CNT_W-1:0] exit_cnt_q;
  reg  [`CNT_W-1:0] odt_age_q;
  reg  [1:0]        rtt_new_q;
  reg               read_busy_q;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  wire cmd_valid = !cmd_in[`CMD_DESEL_BIT];
  wire cmd_lmr   = cmd_valid && (cmd_in == `CMD_LMR);
  wire emr_load  = cmd_lmr && (ba_in == `BA_EMR);
  wire mr_load   = cmd_lmr && (ba_in == `BA_MR);
  wire [1:0] rtt_field = {addr_in[`ADDR_RTT_HI], addr_in[`ADDR_RTT_LO]};
  wire odt_edge  = (odt_in != odt_q);
  wire mod_busy  = (mod_cnt_q != 8'h00);
  wire cke_fall  = cke_q && !cke_in;
  wire cke_rise  = !cke_q && cke_in;
  // Mode delay rounded up to whole cycles; only the counter's width is kept
  wire [31:0] mod_delay_full = `MOD_DELAY_CYC;

  // ----------------------------------------
  // Power state machine
  // ----------------------------------------
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_RESET: if (cke_rise) st_d = ST_ACT;
      ST_ACT: begin
        if (cke_fall && cmd_valid && cmd_in == `CMD_REF && !bank_open_q) st_d = ST_SR;
        else if (cke_fall) st_d = ST_PD;
      end
      ST_PD:   if (cke_rise) st_d = ST_ACT;
      ST_SR:   if (cke_rise) st_d = ST_ACT;
      default: st_d = ST_RESET;
    endcase
  end

  // ----------------------------------------
  // Termination regime
  // ----------------------------------------
  // Regime choice for an ODT edge seen in this cycle
  reg               use_async;
  reg [`CNT_W-1:0]  dly;
  always @* begin
    use_async = 1'b0;
    if (st_q == ST_PD)
      use_async = !bank_open_q || pd_slow_q;
    else if (st_q == ST_ACT && entry_cnt_q < `ENTRY_LEAD_CYC && !cke_in)
      use_async = 1'b1;
    else if (st_q == ST_ACT && exit_cnt_q < `EXIT_LAG_CYC) begin
      if (!odt_in)
        use_async = 1'b1;
      else
        use_async = !bank_open_q || pd_slow_q;
    end
    if (odt_in)
      dly = use_async ? `ASYNC_ON_CYC : `SYNC_ON_CYC;
    else
      dly = use_async ? `ASYNC_OFF_CYC : `SYNC_OFF_CYC;
  end

  // ODT honoured only when enabled, settled and not in self refresh
  wire odt_req = odt_edge && odt_en_q && !mod_busy
                 && (st_q == ST_ACT || st_q == ST_PD);

  // ----------------------------------------
  // Sequential state
  // ----------------------------------------
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q             <= ST_RESET;
      cke_q            <= 1'b0;
      odt_q            <= 1'b0;
      bank_open_q      <= 1'b0;
      pd_slow_q        <= 1'b0;
      odt_en_q         <= 1'b0;
      mod_cnt_q        <= 8'h00;
      entry_cnt_q      <= `CNT_MAX;
      exit_cnt_q       <= `CNT_MAX;
      odt_age_q        <= `CNT_MAX;
      rtt_new_q        <= `RTT_OFF;
      read_busy_q      <= 1'b0;
      in_reset_out     <= 1'b1;
      need_init_out    <= 1'b1;
      powered_down_out <= 1'b0;
      self_refresh_out <= 1'b0;
      async_mode_out   <= 1'b0;
      slow_exit_out    <= 1'b0;
      rtt_sel_out      <= `RTT_OFF;
      rtt_pending_out  <= 1'b0;
      resume_read_out  <= 1'b0;
    end else begin
      st_q  <= st_d;
      cke_q <= cke_in;
      odt_q <= odt_in;
      in_reset_out     <= (st_d == ST_RESET);
      powered_down_out <= (st_d == ST_PD);
      self_refresh_out <= (st_d == ST_SR);
      async_mode_out   <= use_async;
      // Pulse on the CKE rise that ends a drop which cut a read
      resume_read_out  <= cke_rise && read_busy_q;
      entry_cnt_q <= (odt_edge) ? 8'h00 :
                     (entry_cnt_q != `CNT_MAX) ? entry_cnt_q + 8'h01 : entry_cnt_q;
      odt_age_q <= odt_edge ? 8'h00 : (odt_age_q != `CNT_MAX) ? odt_age_q + 8'h01 : odt_age_q;
      if ((st_q == ST_PD || st_q == ST_SR) && cke_rise)
        exit_cnt_q <= 8'h00;
      else if (exit_cnt_q != `CNT_MAX)
        exit_cnt_q <= exit_cnt_q + 8'h01;
      if (mod_busy)
        mod_cnt_q <= mod_cnt_q - 8'h01;
      else if (rtt_pending_out) begin
        rtt_sel_out     <= rtt_new_q;
        rtt_pending_out <= 1'b0;
      end
      if (st_q == ST_RESET) begin
        // Contents lost; every input but CKE is ignored here
        bank_open_q <= 1'b0;
        odt_en_q    <= 1'b0;
        if (cke_rise) need_init_out <= 1'b1;
      end else begin
        if (cmd_valid && cmd_in == `CMD_ACT) bank_open_q <= 1'b1;
        if (cmd_valid && cmd_in == `CMD_PRE) bank_open_q <= 1'b0;
        // Held across a CKE drop so the rise can report the cut read
        if (cmd_valid && cke_in && cmd_in[3:1] == 3'h2)
          read_busy_q <= 1'b1;
        else
          read_busy_q <= read_busy_q && !cke_in;
        if (mr_load) begin
          pd_slow_q     <= addr_in[`ADDR_SLOW_EXIT];
          slow_exit_out <= addr_in[`ADDR_SLOW_EXIT];
          need_init_out <= 1'b0;
        end
        if (emr_load) begin
          odt_en_q        <= (rtt_field != `RTT_OFF);
          rtt_new_q       <= rtt_field;
          rtt_pending_out <= 1'b1;
          mod_cnt_q       <= mod_delay_full[`CNT_W-1:0];
        end
        if (cke_fall && st_q == ST_ACT && !(cmd_valid && cmd_in == `CMD_REF))
          entry_cnt_q <= odt_age_q;
      end
    end
  end

  // ----------------------------------------
  // Termination delay line
  // ----------------------------------------
  odt_delay_line u_delay (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .req_in      (odt_req),
    .level_in    (odt_in),
    .delay_in    (dly),
    .term_on_out (term_on_out)
  );
endmodule // dram_cke_reset_odt_timing
`default_nettype wire

// ===== dram_odt_consts.vh
// Constants for the CKE reset and on-die termination timing block
`ifndef DRAM_ODT_CONSTS_VH
`define DRAM_ODT_CONSTS_VH
`define CLK_PERIOD_PS      32'd8000
`define MOD_DELAY_PS       32'd12000
`define MOD_DELAY_CYC      (((`MOD_DELAY_PS) + (`CLK_PERIOD_PS) - 32'd1) / (`CLK_PERIOD_PS))
`define CNT_W              8
`define CNT_MAX            8'hff
`define ENTRY_LEAD_CYC     8'h03
`define EXIT_LAG_CYC       8'h03
`define SYNC_ON_CYC        8'h02
`define SYNC_OFF_CYC       8'h02
`define ASYNC_ON_CYC       8'h03
`define ASYNC_OFF_CYC      8'h03
`define CMD_NOP            4'h7
`define CMD_DESEL_BIT      3
`define CMD_LMR            4'h0
`define CMD_ACT            4'h3
`define CMD_PRE            4'h2
`define CMD_REF            4'h1
`define BA_EMR             3'h1
`define BA_MR              3'h0
`define ADDR_SLOW_EXIT     12
`define ADDR_RTT_HI        6
`define ADDR_RTT_LO        2
`define RTT_OFF            2'h0
`endif

// ===== odt_delay_line.v
// Delay line that applies a selectable termination turn-on or turn-off latency
`timescale 1ns/1ps
`default_nettype none
`include "dram_odt_consts.vh"
module odt_delay_line (
  // Clock and reset
  input  wire                clk_in,
  input  wire                rst_n_in,
  // Request
  input  wire                req_in,
  input  wire                level_in,
  input  wire [`CNT_W-1:0]   delay_in,
  // Termination state
  output reg                 term_on_out
);
  reg [`CNT_W-1:0] cnt_q;
  reg              pend_q;
  reg              lvl_q;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q       <= 8'h00;
      pend_q      <= 1'b0;
      lvl_q       <= 1'b0;
      term_on_out <= 1'b0;
    end else if (req_in) begin
      // A newer request replaces one still in flight
      cnt_q  <= delay_in;
      pend_q <= 1'b1;
      lvl_q  <= level_in;
    end else if (pend_q) begin
      if (cnt_q <= 8'h01) begin
        pend_q      <= 1'b0;
        term_on_out <= lvl_q;
      end else begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule // odt_delay_line
`default_nettype wire

// ===== odt_timing_monitor.sv
// Checker of the CKE reset and termination timing block
`timescale 1ns/1ps
`default_nettype none
`include "dram_odt_consts.vh"
module odt_timing_monitor (
  input wire logic        clk_in, rst_n_in, cke_in, odt_in,
  input wire logic [3:0]  cmd_in,
  input wire logic [2:0]  ba_in,
  input wire logic [13:0] addr_in,
  input wire logic        in_reset_out, need_init_out, powered_down_out, self_refresh_out,
  input wire logic        async_mode_out, slow_exit_out, rtt_pending_out, term_on_out, resume_read_out,
  input wire logic [1:0]  rtt_sel_out
);
  logic odt_q;
  wire  lm_w = cmd_in == `CMD_LMR && cke_in && !in_reset_out;
  wire  edge_w = odt_in != odt_q;
  always @(posedge clk_in) odt_q <= odt_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  quiet_reset_a:
    assert property (in_reset_out |-> !term_on_out && !powered_down_out) else $error("active in reset");
  init_flag_a:
    assert property (in_reset_out |-> need_init_out) else $error("init flag low");
  mr_load_a:
    assert property (lm_w && ba_in == `BA_MR |=> !need_init_out && slow_exit_out == $past(addr_in[12]))
      else $error("mode load lost");
  emr_pend_a:
    assert property (lm_w && ba_in == `BA_EMR |=> rtt_pending_out) else $error("no pending update");
  pend_len_a:
    assert property ($rose(rtt_pending_out) |=> rtt_pending_out ##1 rtt_pending_out ##1 !rtt_pending_out)
      else $error("pending length");
  rtt_value_a:
    assert property (lm_w && ba_in == `BA_EMR |-> ##4 rtt_sel_out == {$past(addr_in[6], 4), $past(addr_in[2], 4)})
      else $error("termination code wrong");
  sync_mode_a:
    assert property (cke_in [*8] ##0 edge_w |=> !async_mode_out) else $error("async while active");
  slow_async_a:
    assert property ((slow_exit_out && powered_down_out) [*4] ##0 edge_w |=> async_mode_out) else $error("sync in pd");
  sr_hold_a:
    assert property (self_refresh_out [*6] |-> $stable(term_on_out)) else $error("odt in self refresh");
  read_pulse_a:
    assert property (resume_read_out |=> !resume_read_out) else $error("resume not a pulse");
  cover property (lm_w && ba_in == `BA_EMR);
  cover property (powered_down_out && async_mode_out);
  cover property ($fell(in_reset_out));
  cover property (resume_read_out);
endmodule // odt_timing_monitor
bind dram_cke_reset_odt_timing odt_timing_monitor u_mon (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .cke_in(cke_in), .odt_in(odt_in), .cmd_in(cmd_in), .ba_in(ba_in), .addr_in(addr_in),
  .in_reset_out(in_reset_out), .need_init_out(need_init_out), .powered_down_out(powered_down_out),
  .self_refresh_out(self_refresh_out), .async_mode_out(async_mode_out), .slow_exit_out(slow_exit_out),
  .rtt_pending_out(rtt_pending_out), .term_on_out(term_on_out), .resume_read_out(resume_read_out),
  .rtt_sel_out(rtt_sel_out));
`default_nettype wire

// ===== dram_ctrl_model.sv
// Controller model driving CKE, ODT and commands
`timescale 1ns/1ps
`default_nettype none
`include "dram_odt_consts.vh"
module dram_ctrl_model (
  input  wire logic        clk_in,
  output var  logic        cke_out,
  output var  logic        odt_out,
  output var  logic [3:0]  cmd_out,
  output var  logic [2:0]  ba_out,
  output var  logic [13:0] addr_out
);
  initial begin
    cke_out = 1'b0;
    odt_out = 1'b0;
    cmd_out = `CMD_NOP;
    ba_out = 3'h0;
    addr_out = 14'h0;
  end
  // Address flips after each command so a stale value never looks like a fresh one
  task issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a, input logic k);
    @(negedge clk_in);
    cmd_out = c;
    ba_out = b;
    addr_out = a;
    cke_out = k;
    @(negedge clk_in);
    cmd_out = `CMD_NOP;
    ba_out = ~b;
    addr_out = ~a;
    repeat (2) @(negedge clk_in);
  endtask
  localparam logic [3:0] CMD_READ = 4'h5;
  task read_cut(input logic [13:0] a);
    @(negedge clk_in);
    cmd_out = CMD_READ;
    addr_out = a;
    @(negedge clk_in);
    // Clocks keep running through the drop, so the reset delay is always met
    cmd_out = `CMD_NOP;
    cke_out = 1'b0;
    repeat (3) @(negedge clk_in);
  endtask
  task set_odt(input logic v);
    @(negedge clk_in);
    odt_out = v;
  endtask
endmodule // dram_ctrl_model
`default_nettype wire

// ===== test_dram_cke_reset_odt_timing.sv
// Self-checking bench for the CKE reset and termination timing block
`timescale 1ns/1ps
`default_nettype none
`include "dram_odt_consts.vh"
module test_dram_cke_reset_odt_timing;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  wire         cke, odt, in_rst, n_init, pd, sr, asy, slow, pend, term, resume;
  wire [3:0]   cmd;
  wire [2:0]   ba;
  wire [13:0]  addr;
  wire [1:0]   rtt;
  int          n_errors = 0;
  int          checks = 0;
  int          exp_rtt = 0;
  int          n_resume = 0;
  initial forever #4 clk_in = ~clk_in;
  // Resume pulses last one cycle, so they are counted away from the edge that makes them
  always @(negedge clk_in) begin
    if (resume === 1'b1) n_resume++;
  end
  dram_ctrl_model u_ctrl (.clk_in(clk_in), .cke_out(cke), .odt_out(odt), .cmd_out(cmd), .ba_out(ba),
    .addr_out(addr));
  dram_cke_reset_odt_timing u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cke_in(cke), .odt_in(odt),
    .cmd_in(cmd), .ba_in(ba), .addr_in(addr), .in_reset_out(in_rst), .need_init_out(n_init),
    .powered_down_out(pd), .self_refresh_out(sr), .async_mode_out(asy), .slow_exit_out(slow),
    .rtt_sel_out(rtt), .rtt_pending_out(pend), .term_on_out(term), .resume_read_out(resume));
  task check(input logic [1:0] seen, input logic [1:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task chk1(input logic s, input logic e);
    check({1'b0, s}, {1'b0, e});
  endtask
  task wait_n(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task complete_run;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_in);
    n_errors++;
    complete_run;
  end
  initial begin
    void'($urandom(32'hb3c0));
    wait_n(4);
    rst_n_in = 1'b1;
    chk1(in_rst, 1'b1);
    u_ctrl.issue(`CMD_LMR, `BA_EMR, 14'h0044, 1'b0);
    check(rtt, 2'h0);
    u_ctrl.issue(`CMD_NOP, 3'($urandom), 14'($urandom), 1'b1);
    chk1(in_rst, 1'b0);
    chk1(n_init, 1'b1);
    u_ctrl.issue(`CMD_LMR, `BA_MR, 14'h1000, 1'b1);
    chk1(n_init, 1'b0);
    chk1(slow, 1'b1);
    $display("test reset_exit done");
    for (int k = 0; k < 4; k++) begin
      exp_rtt = k;
      u_ctrl.issue(`CMD_LMR, `BA_EMR, (14'($urandom) & 14'h2fbb) | 14'({exp_rtt[1], 3'h0, exp_rtt[0], 2'h0}), 1'b1);
      wait_n(2);
      check(rtt, 2'(exp_rtt));
      chk1(pend, 1'b0);
    end
    $display("test rtt_codes done");
    u_ctrl.set_odt(1'b1);
    wait_n(6);
    chk1(term, 1'b1);
    chk1(asy, 1'b0);
    u_ctrl.set_odt(1'b0);
    wait_n(6);
    chk1(term, 1'b0);
    u_ctrl.issue(`CMD_NOP, 3'($urandom), 14'($urandom), 1'b0);
    chk1(pd, 1'b1);
    wait_n(2);
    u_ctrl.set_odt(1'b1);
    wait_n(6);
    chk1(asy, 1'b1);
    chk1(term, 1'b1);
    u_ctrl.set_odt(1'b0);
    wait_n(6);
    u_ctrl.issue(`CMD_NOP, 3'($urandom), 14'($urandom), 1'b1);
    chk1(pd, 1'b0);
    $display("test power_down done");
    u_ctrl.read_cut(14'($urandom));
    chk1(pd, 1'b1);
    u_ctrl.issue(`CMD_NOP, 3'($urandom), 14'($urandom), 1'b1);
    check(2'(n_resume), 2'h1);
    $display("test read_cut done");
    u_ctrl.issue(`CMD_REF, 3'($urandom), 14'($urandom), 1'b0);
    chk1(sr, 1'b1);
    u_ctrl.set_odt(1'b1);
    wait_n(6);
    chk1(term, 1'b0);
    u_ctrl.set_odt(1'b0);
    u_ctrl.issue(`CMD_NOP, 3'($urandom), 14'($urandom), 1'b1);
    chk1(sr, 1'b0);
    $display("test self_refresh done");
    rst_n_in = 1'b0;
    wait_n(1);
    chk1(in_rst, 1'b1);
    check(rtt, 2'h0);
    rst_n_in = 1'b1;
    wait_n(2);
    chk1(n_init, 1'b1);
    $display("test second_reset done");
    complete_run;
  end
endmodule // test_dram_cke_reset_odt_timing
`default_nettype wire
